/* shared/sar_params.svh */
// timing, address and field constants for the serial readout converter
// Behaviour
// R01: the driver of the data line changes it only while the serial clock is low
// R02: a data change while the clock is high is a start or stop, never a bit
// R03: the data line is only pulled low or released, never driven high
// R04: the serial clock is only an input; the bus master alone makes it
// R05: each finished conversion lands in a 12-bit holding register, read without disturbing it
// R06: acquisition and conversion are timed by the internal clock, not the serial clock
// R07: the result is shifted out most significant bit first
// R08: results are straight unsigned binary, zero low, all ones full scale
// R09: the conversion phase lasts typically 8.96 us of internal time
// R10: the acquisition phase lasts typically 1.12 us of internal time
// R11: a single conversion is start, address, two data bytes read, then stop
// R12: a master acknowledge asks for the next result within 18 serial clocks
// R13: continuous mode sustains up to 22.3 ksps with a 400 kHz serial clock
// R14: sampling starts on the falling clock edge ending a read-direction address bit
// R15: after address acknowledge send four zeros and upper nibble, then the low byte
// R16: a write-direction address is acknowledged, then the bus released without converting
// R17: a master not-acknowledge makes the device release the line for the stop
// R18: stay idle and released until a start plus a matching address arrives
// R19: a start in mid-transfer aborts back to address reception; a stop returns the link to idle instead
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH

`define SAR_RES_W 12
`define SAR_PAD_BITS 4
`define SAR_BYTE_BITS 8
`define SAR_CLK_MHZ 250
`define SAR_ACQ_NS 1120
`define SAR_CONV_NS 8960
`define SAR_ACQ_CYC ((`SAR_ACQ_NS * `SAR_CLK_MHZ + 999) / 1000)
`define SAR_CONV_CYC ((`SAR_CONV_NS * `SAR_CLK_MHZ + 999) / 1000)
`define SAR_STEP_CYC ((`SAR_CONV_CYC + `SAR_RES_W - 1) / `SAR_RES_W)
`define SAR_SCL_KHZ 400
`define SAR_CONT_CLKS 18
`define SAR_RATE_SPS 22300
// device code value is arbitrary
`define SAR_DEV_CODE 4'h6
`define SAR_ADDR_BITS 3'h5
`define SAR_RW_POS 0

`endif

/* shared/sar_pkg.sv */
// state types of the serial readout converter
package sar_pkg;

  typedef enum logic [2:0] {
    LK_IDLE = 3'b000,
    LK_ADDR = 3'b001,
    LK_AACK = 3'b010,
    LK_TX = 3'b011,
    LK_TACK = 3'b100,
    LK_SKIP = 3'b101
  } sar_link_st_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_ACQ = 2'b01,
    ENG_CONV = 2'b10
  } sar_eng_st_t;

endpackage

/* verilog/sar_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/100ps
module sar_sync #(
  parameter int WIDTH = 1
) (
  // clock of the receiving domain
  input wire logic clk,
  // level from another domain or a pin
  input wire logic [WIDTH-1:0] din,
  // synchronised level
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q <= din;
    dout <= meta_q;
  end

endmodule

/* verilog/sar_busmon.sv */
// serial bus condition detector on synchronised clock and data levels
`timescale 1ns/100ps
module sar_busmon (
  // link clock and reset
  input wire logic clk,
  input wire logic rst,
  // synchronised bus levels
  input wire logic scl_s,
  input wire logic sda_s,
  // detected conditions, one link cycle each
  output logic scl_rise,
  output logic scl_fall,
  output logic bus_start,
  output logic bus_stop
);

  logic scl_p_q;
  logic sda_p_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  // data moving while the clock stays high is a condition, not a bit
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s; // R02
  assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s; // R02

endmodule

/* verilog/sar_adc_top.sv */
// serial bus slave with self-timed successive approximation control
`timescale 1ns/100ps
`include "sar_params.svh"
module sar_adc_top
  import sar_pkg::*;
#(
  parameter int RES_W = `SAR_RES_W,
  parameter int ACQ_CYC = `SAR_ACQ_CYC,
  parameter int STEP_CYC = `SAR_STEP_CYC,
  parameter logic [3:0] DEV_CODE = `SAR_DEV_CODE,
  parameter logic [2:0] ADDR_BITS = `SAR_ADDR_BITS
) (
  // converter clock and reset
  input wire logic clock,
  input wire logic reset,
  // link sampling clock
  input wire logic link_clk,
  // serial bus pins, clock is input only
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // analog front end
  input wire logic cmp_above,
  output logic sample_en,
  output logic [RES_W-1:0] dac_code,
  // holding register and status
  output logic [RES_W-1:0] result,
  output logic busy
);

  localparam int CNT_W = $clog2(((ACQ_CYC > STEP_CYC) ? ACQ_CYC : STEP_CYC) + 1);
  localparam int IDX_W = $clog2(RES_W);

  // converter domain
  sar_eng_st_t eng_st_q;
  logic [CNT_W-1:0] eng_cnt_q;
  logic [IDX_W-1:0] bit_idx_q;
  logic eng_done_tgl_q;
  logic req_tgl_q;
  logic req_s;
  logic req_p_q;
  logic cmp_s;
  logic conv_start;
  logic [1:0] settle_q;

  sar_sync #(.WIDTH(1)) u_req_sync (
    .clk(clock),
    .din(req_tgl_q),
    .dout(req_s)
  );

  sar_sync #(.WIDTH(1)) u_cmp_sync (
    .clk(clock),
    .din(cmp_above),
    .dout(cmp_s)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      req_p_q <= 1'b0;
      settle_q <= 2'h0;
    end else begin
      req_p_q <= req_s;
      if (settle_q != 2'h3) begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  // each link toggle is one start request; masked while the link side still leaves reset
  assign conv_start = (req_s ^ req_p_q) & (settle_q == 2'h3);

  // keep the decided bit, try the next lower one
  function automatic logic [RES_W-1:0] sar_trial(
    input logic [RES_W-1:0] code,
    input logic [IDX_W-1:0] idx,
    input logic keep
  );
    logic [RES_W-1:0] nxt;
    nxt = code;
    nxt[idx] = keep;
    if (idx != '0) begin
      nxt[idx - 1'b1] = 1'b1;
    end
    return nxt;
  endfunction

  // phase sequencing; requests during a running cycle are dropped
  always_ff @(posedge clock) begin
    if (reset) begin
      eng_st_q <= ENG_IDLE;
      eng_cnt_q <= '0;
      bit_idx_q <= '0;
    end else begin
      unique case (eng_st_q)
        ENG_IDLE: begin
          if (conv_start) begin
            eng_st_q <= ENG_ACQ;
            eng_cnt_q <= '0;
          end
        end
        ENG_ACQ: begin
          if (eng_cnt_q == CNT_W'(ACQ_CYC - 1)) begin // R10 R06
            eng_st_q <= ENG_CONV;
            eng_cnt_q <= '0;
            bit_idx_q <= IDX_W'(RES_W - 1);
          end else begin
            eng_cnt_q <= eng_cnt_q + 1'b1;
          end
        end
        ENG_CONV: begin
          if (eng_cnt_q == CNT_W'(STEP_CYC - 1)) begin // R09 R06
            eng_cnt_q <= '0;
            if (bit_idx_q == '0) begin
              eng_st_q <= ENG_IDLE;
            end else begin
              bit_idx_q <= bit_idx_q - 1'b1;
            end
          end else begin
            eng_cnt_q <= eng_cnt_q + 1'b1;
          end
        end
        default: begin
          eng_st_q <= ENG_IDLE;
        end
      endcase
    end
  end

  // sample switch, busy flag and trial code
  always_ff @(posedge clock) begin
    if (reset) begin
      sample_en <= 1'b0;
      busy <= 1'b0;
      dac_code <= '0;
    end else begin
      sample_en <= (eng_st_q == ENG_IDLE) ? conv_start :
                   (eng_st_q == ENG_ACQ) && (eng_cnt_q != CNT_W'(ACQ_CYC - 1));
      if (eng_st_q == ENG_IDLE && conv_start) begin
        busy <= 1'b1;
      end else if (eng_st_q == ENG_CONV && eng_cnt_q == CNT_W'(STEP_CYC - 1)
                   && bit_idx_q == '0) begin
        busy <= 1'b0;
      end
      if (eng_st_q == ENG_ACQ && eng_cnt_q == CNT_W'(ACQ_CYC - 1)) begin
        dac_code <= {1'b1, {(RES_W - 1){1'b0}}};
      end else if (eng_st_q == ENG_CONV && eng_cnt_q == CNT_W'(STEP_CYC - 1)) begin
        // input above the trial keeps the bit: straight binary
        dac_code <= sar_trial(dac_code, bit_idx_q, cmp_s); // R08
      end
    end
  end

  // holding register, written only when a conversion ends
  always_ff @(posedge clock) begin
    if (reset) begin
      result <= '0;
      eng_done_tgl_q <= 1'b0;
    end else if (eng_st_q == ENG_CONV && eng_cnt_q == CNT_W'(STEP_CYC - 1)
                 && bit_idx_q == '0) begin
      result <= sar_trial(dac_code, bit_idx_q, cmp_s); // R05 R08
      eng_done_tgl_q <= ~eng_done_tgl_q;
    end
  end

  // link domain
  logic link_rst;
  logic [1:0] pin_s;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic done_s;
  logic done_p_q;
  logic [RES_W-1:0] res_lk_q;
  sar_link_st_t lk_st_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic rd_q;
  logic byte_q;

  sar_sync #(.WIDTH(1)) u_rst_sync (
    .clk(link_clk),
    .din(reset),
    .dout(link_rst)
  );

  // the serial clock is only ever sampled, never driven
  sar_sync #(.WIDTH(2)) u_pin_sync (
    .clk(link_clk),
    .din({scl_i, sda_i}), // R04
    .dout(pin_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  sar_busmon u_busmon (
    .clk(link_clk),
    .rst(link_rst),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .bus_start(bus_start),
    .bus_stop(bus_stop)
  );

  sar_sync #(.WIDTH(1)) u_done_sync (
    .clk(link_clk),
    .din(eng_done_tgl_q),
    .dout(done_s)
  );

  // result is stable for a whole conversion after each done toggle
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      done_p_q <= 1'b0;
      res_lk_q <= '0;
    end else begin
      done_p_q <= done_s;
      if (done_s ^ done_p_q) begin
        res_lk_q <= result; // R05
      end
    end
  end

  // bit to send: pad zeros and upper nibble, then the low byte
  function automatic logic tx_bit(
    input logic [RES_W-1:0] res,
    input logic low_byte,
    input logic [2:0] idx
  );
    logic [7:0] word;
    word = low_byte ? res[7:0] : {{`SAR_PAD_BITS{1'b0}}, res[RES_W-1:8]}; // R15
    return word[3'h7 - idx]; // R07
  endfunction

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0; // R03
    end
  end

  // transaction sequencer; line changes only after a detected falling edge
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lk_st_q <= LK_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      rd_q <= 1'b0;
      byte_q <= 1'b0;
      sda_oe <= 1'b0;
      req_tgl_q <= 1'b0;
    end else if (bus_start) begin
      lk_st_q <= LK_ADDR; // R19 R02
      bit_cnt_q <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      lk_st_q <= LK_IDLE; // R19 R02
      sda_oe <= 1'b0;
    end else begin
      unique case (lk_st_q)
        LK_IDLE, LK_SKIP: begin
          sda_oe <= 1'b0; // R18
        end
        LK_ADDR: begin
          if (scl_rise && bit_cnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            if (shift_q[7:1] == {DEV_CODE, ADDR_BITS}) begin
              lk_st_q <= LK_AACK;
              sda_oe <= 1'b1;
              rd_q <= shift_q[`SAR_RW_POS];
              if (shift_q[`SAR_RW_POS]) begin
                req_tgl_q <= ~req_tgl_q; // R14
              end
            end else begin
              lk_st_q <= LK_SKIP; // R18
            end
          end
        end
        LK_AACK: begin
          if (scl_fall) begin
            if (rd_q) begin
              lk_st_q <= LK_TX;
              byte_q <= 1'b0;
              bit_cnt_q <= 4'h0;
              sda_oe <= ~tx_bit(res_lk_q, 1'b0, 3'h0); // R01 R03 R15
            end else begin
              lk_st_q <= LK_SKIP; // R16
              sda_oe <= 1'b0;
            end
          end
        end
        LK_TX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              lk_st_q <= LK_TACK;
              sda_oe <= 1'b0;
              if (byte_q) begin
                req_tgl_q <= ~req_tgl_q; // R12 R13
              end
            end else begin
              sda_oe <= ~tx_bit(res_lk_q, byte_q, bit_cnt_q[2:0]); // R01 R03 R07
            end
          end
        end
        LK_TACK: begin
          if (scl_rise && sda_s) begin
            lk_st_q <= LK_SKIP; // R17
          end else if (scl_fall) begin
            lk_st_q <= LK_TX; // R12
            byte_q <= ~byte_q;
            bit_cnt_q <= 4'h0;
            sda_oe <= ~tx_bit(res_lk_q, ~byte_q, 3'h0); // R01 R15
          end
        end
        default: begin
          lk_st_q <= LK_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* verif/sar_props.sv */
// checker of converter timing and link pin behaviour
`timescale 1ns/100ps
module sar_props #(
  parameter int RES_W = 12,
  parameter int ACQ_CYC = 280,
  parameter int STEP_CYC = 187
) (
  // clocks and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic link_clk,
  // link pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // converter outputs
  input wire logic sample_en,
  input wire logic [RES_W-1:0] dac_code,
  input wire logic [RES_W-1:0] result,
  input wire logic busy
);
  logic [15:0] acq_q;
  logic [15:0] conv_q;
  logic [3:0] lk_rst_q;
  logic lk_hold;
  // link logic leaves reset a few link cycles after the converter side
  always_ff @(posedge link_clk) begin
    lk_rst_q <= {lk_rst_q[2:0], reset};
  end
  assign lk_hold = reset || (lk_rst_q != 4'h0);
  // cycles spent sampling and converting
  always_ff @(posedge clock) begin
    acq_q <= (reset || !sample_en) ? 16'h0 : acq_q + 16'h1;
  end
  always_ff @(posedge clock) begin
    conv_q <= (reset || !busy || sample_en) ? 16'h0 : conv_q + 16'h1;
  end
  sequence s_acq_end;
    $fell(sample_en) ##0 busy;
  endsequence
  AST_OPEN_DRAIN: assert property (@(posedge link_clk) disable iff (lk_hold) !sda_o)
    else $error("data pin driven high");
  AST_PIN_CHG: assert property (@(posedge link_clk) disable iff (lk_hold)
    $changed(sda_oe) |-> !scl_i && !$past(scl_i)) else $error("data pin moved, clock high");
  AST_ACQ_LEN: assert property (@(posedge clock) disable iff (reset)
    $fell(sample_en) |-> acq_q == ACQ_CYC) else $error("acquisition length wrong");
  AST_CONV_LEN: assert property (@(posedge clock) disable iff (reset)
    $fell(busy) |-> conv_q == RES_W * STEP_CYC) else $error("conversion length wrong");
  AST_MSB_TRIAL: assert property (@(posedge clock) disable iff (reset)
    s_acq_end |-> dac_code == 12'h800) else $error("first trial code wrong");
  AST_SAMPLE_FIRST: assert property (@(posedge clock) disable iff (reset)
    $rose(busy) |-> sample_en ##1 sample_en) else $error("conversion without sampling");
  AST_RES_HOLD: assert property (@(posedge clock) disable iff (reset)
    $changed(result) |-> $fell(busy)) else $error("result changed mid conversion");
  AST_DAC_BUSY: assert property (@(posedge clock) disable iff (reset)
    $changed(dac_code) |-> busy || $past(busy)) else $error("trial code moved while idle");
endmodule
bind sar_adc_top sar_props #(.RES_W(RES_W), .ACQ_CYC(ACQ_CYC), .STEP_CYC(STEP_CYC)) u_props (
  .clock(clock), .reset(reset), .link_clk(link_clk), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .sample_en(sample_en), .dac_code(dac_code), .result(result), .busy(busy));

/* verif/sar_bm.sv */
// bit level two-wire bus master for the converter link
`timescale 1ns/100ps
module sar_bm (
  // timing reference
  input wire logic clock,
  // bus wires, data resolved outside
  output logic scl,
  output logic sda_low,
  input wire logic sda,
  // per byte report: wire bits then acknowledge bit
  output logic [8:0] rx_word,
  output logic rx_stb
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rx_word = 9'h0;
    rx_stb = 1'b0;
  end
  task automatic half();
    repeat (15) @(negedge clock);
  endtask
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask
  // fewer than 8 bits leaves the byte cut short with no report
  task automatic xfer(input logic [7:0] d, input logic ack, input int n);
    logic [8:0] w;
    w = 9'h0;
    for (int i = 7; i > 7 - n; i--) begin
      bit_io(d[i], w[i+1]);
    end
    if (n == 8) begin
      bit_io(ack, w[0]);
      rx_word = w;
      rx_stb = 1'b1;
      @(negedge clock);
      rx_stb = 1'b0;
    end
  endtask
endmodule

/* verif/tb.sv */
// self-checking bench: bus frames against a modelled analog input
`timescale 1ns/100ps
module tb;
  logic clock;
  logic reset;
  logic link_clk;
  logic m_scl;
  logic m_low;
  logic rx_stb;
  logic [8:0] rx_word;
  logic sda_o;
  logic sda_oe;
  logic sample_en;
  logic busy;
  logic [11:0] dac_code;
  logic [11:0] result;
  logic [11:0] vin;
  logic [8:0] exp_q[$];
  int seed = 7;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  // pull-up: released wire reads high
  wire sda = !(m_low || (sda_oe && !sda_o));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  sar_adc_top #(.ACQ_CYC(8), .STEP_CYC(4)) u_sar_adc_top (
    .clock(clock), .reset(reset), .link_clk(link_clk), .scl_i(m_scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .cmp_above(vin >= dac_code), .sample_en(sample_en),
    .dac_code(dac_code), .result(result), .busy(busy));
  sar_bm u_sar_bm (.clock(clock), .scl(m_scl), .sda_low(m_low), .sda(sda),
    .rx_word(rx_word), .rx_stb(rx_stb));
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic addr(input logic [7:0] a, input logic nak);
    exp_q.push_back({a, nak});
    u_sar_bm.xfer(a, 1'b1, 8);
  endtask
  task automatic rd(input logic [8:0] e);
    exp_q.push_back(e);
    u_sar_bm.xfer(8'hff, e[0], 8);
  endtask
  task automatic read_pair(input logic last);
    logic [11:0] v;
    v = vin;
    rd({4'h0, v[11:8], 1'b0});
    cmp(result, v);
    cmp({11'h0, busy}, 12'h0);
    vin = 12'($random(seed));
    rd({v[7:0], last});
  endtask
  always @(posedge rx_stb) begin
    cmp({3'h0, rx_word}, (exp_q.size() == 0) ? 12'hx : {3'h0, exp_q.pop_front()});
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    reset = 1'b1;
    vin = 12'h0;
    repeat (5) @(negedge clock);
    reset = 1'b0;
    repeat (20) @(negedge clock);
    for (int k = 0; k < 5; k++) begin
      vin = (k == 0) ? 12'h0 : (k == 1) ? 12'hfff : 12'($random(seed));
      u_sar_bm.start();
      addr(8'h6b, 1'b0);
      read_pair(1'b1);
      u_sar_bm.stop();
    end
    u_sar_bm.start();
    addr(8'h6b, 1'b0);
    repeat (3) read_pair(1'b0);
    read_pair(1'b1);
    u_sar_bm.stop();
    u_sar_bm.start();
    addr(8'h6a, 1'b0);
    cmp({11'h0, busy}, 12'h0);
    rd(9'h1ff);
    u_sar_bm.stop();
    u_sar_bm.start();
    addr(8'h56, 1'b1);
    rd(9'h1ff);
    cmp({11'h0, busy}, 12'h0);
    u_sar_bm.stop();
    u_sar_bm.start();
    u_sar_bm.xfer(8'h6b, 1'b1, 4);
    u_sar_bm.start();
    addr(8'h6b, 1'b0);
    read_pair(1'b1);
    u_sar_bm.stop();
    repeat (20) @(negedge clock);
    close_out();
  end
endmodule
